/* hw/core_decode.sv */
// instruction decode, stack, data pointers and memory map of the 16-bit core
// Notes on behaviour
// - bit 15 selects immediate or register source.
// - source comes from instruction bits 0 to 7.
// - register source: low nibble module, high nibble index.
// - bits 8 to 14 are destination: low four module, high three subindex.
// - upper destinations need a prior prefix write, one extra cycle.
// - fetch and execute in one cycle, no pipeline.
// - every instruction is a register move; operations are side effects.
// - fixed 16-bit words; accumulator pairs with any register.
// - internal stack of sixteen 16-bit entries.
// - call, return, interrupt and explicit push/pop use the stack.
// - stack pointer resets to fifteen.
// - push-type operations increment pointer, then write.
// - pop-type operations read, then decrement pointer.
// - three data pointers step automatically after access.
// - utility ROM of 4K words sits at 8000h by default.
// - code and data spaces are separate by default.
// - a mode maps data memory into code space for execution.
// - a mode maps code memory into data space for constants.
// - pseudo-Von Neumann mode gives one contiguous map.
// - data is 256 words; code is up to 64K words.
// - outside code access can be blocked by a 16-word key.
// - after reset execution starts in the utility ROM.
// - key words are checked against the code word fetched at the program counter.
// - lock bit set at reset demands the key; clearing removes it.
`timescale 1ns/1ps
`include "core_defines.svh"
module core_decode #(
  parameter int DATA_AW = 8,
  parameter int CODE_AW = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // program memory
  output logic [15:0] codeAddr,
  input wire logic [15:0] codeRdata,
  output logic codeSelUrom,
  output logic codeSelData,
  // data memory
  output logic [15:0] dataAddr,
  output logic dataRd,
  output logic dataWr,
  output logic [15:0] dataWdata,
  output logic dataSelCode,
  input wire logic [15:0] dataRdata,
  // peripheral register modules
  output logic [3:0] perMod,
  output logic [3:0] perSrcIdx,
  output logic [7:0] perDstIdx,
  output logic perRd,
  output logic perWr,
  output logic [15:0] perWdata,
  input wire logic [15:0] perRdata,
  // interrupt request and vector
  input wire logic irqReq,
  input wire logic [15:0] irqVector,
  // memory map mode and lock control
  input wire logic [1:0] mapMode,
  input wire logic lockClear,
  // debug tool key entry, from a pin-side unit
  input wire logic keyValid,
  input wire logic [15:0] keyWord,
  output logic keyReq,
  output logic [3:0] keyIdx,
  // status
  output logic codeLockBit,
  output logic toolAccessOk,
  output logic [15:0] accValue,
  output logic [3:0] stackPointer,
  output logic [15:0] progCounter
);
  import core_pkg::*;

  // ==========================================
  // instruction fields
  wire logic [15:0] instr = codeRdata;
  wire logic srcImm = ~instr[`FMT_BIT];
  wire logic [7:0] srcField = instr[`SRC_MSB:`SRC_LSB];
  wire logic [3:0] srcMod = srcField[`SRC_MOD_W-1:0];
  wire logic [3:0] srcIdx = srcField[7:`SRC_MOD_W];
  wire logic [3:0] dstMod = instr[`DST_LSB+`DST_MOD_W-1:`DST_LSB];
  wire logic [2:0] dstSub = instr[`DST_MSB:`DST_LSB+`DST_MOD_W];

  // ==========================================
  // state registers
  logic [15:0] pc_ff;
  logic [15:0] nxt_pc;
  logic [15:0] acc_ff;
  logic [15:0] nxt_acc;
  logic [4:0] prefix_ff;
  logic [4:0] nxt_prefix;
  logic lock_ff;
  logic [1:0] step_ff [3];
  pw_state_t pw_ff;
  pw_state_t nxt_pw;
  logic [3:0] key_idx_ff;
  logic key_bad_ff;

  // full destination index combines prefix bits with the subindex
  wire logic [7:0] dstIdx = {prefix_ff, dstSub};
  wire logic dstSys = dstMod[3] && (prefix_ff == 5'h00);
  wire logic [15:0] stackTop;
  wire logic [15:0] ptrVal [3];

  // ==========================================
  // source selection
  wire logic srcIsAcc = !srcImm && (srcMod == `MOD_ACC);
  wire logic srcIsPtrMem = !srcImm && (srcMod == `MOD_PTR);
  wire logic srcIsStackPtr = !srcImm && (srcMod == `MOD_STACK) && (srcIdx == `IDX_STACKPTR);
  wire logic popOp = !srcImm && (srcMod == `MOD_STACK) && (srcIdx == `IDX_POP);
  wire logic popiOp = !srcImm && (srcMod == `MOD_STACK) && (srcIdx == `IDX_STACK_LOAD_INT_OP);
  wire logic srcIsPtrCtl = !srcImm && (srcMod == `MOD_PTRCTL);
  wire logic [1:0] ptrSel = (srcIdx == `IDX_PTR1) ? 2'd1 : ((srcIdx == `IDX_PTR2) ? 2'd2 : 2'd0);
  wire logic [1:0] dstPtrSel = (dstSub == 3'd1) ? 2'd1 : ((dstSub == 3'd2) ? 2'd2 : 2'd0);
  wire logic [15:0] srcValue =
    srcImm ? {8'h00, srcField} :
    srcIsAcc ? acc_ff :
    srcIsStackPtr ? {12'h000, stackPointer} :
    (popOp || popiOp) ? stackTop :
    srcIsPtrMem ? dataRdata :
    srcIsPtrCtl ? {14'h0000, step_ff[ptrSel]} :
    perRdata;

  // ==========================================
  // destination side effects
  wire logic dstIsAcc = dstSys && (dstMod == `MOD_ACC);
  wire logic dstIsPrefix = (dstMod == `MOD_PREFIX);
  wire logic dstIsIp = dstSys && (dstMod == `MOD_IP);
  wire logic dstIsStack = dstSys && (dstMod == `MOD_STACK);
  wire logic pushOp = dstIsStack && ({1'b0, dstSub} == `IDX_PUSH);
  wire logic callOp = dstIsStack && ({1'b0, dstSub} == `IDX_CALL);
  wire logic retOp = dstIsStack && ({1'b0, dstSub} == `IDX_RET);
  wire logic retiOp = dstIsStack && ({1'b0, dstSub} == `IDX_INTERRUPT_EXIT);
  wire logic dstIsPtrMem = dstSys && (dstMod == `MOD_PTR);
  wire logic dstIsPtrCtl = dstSys && (dstMod == `MOD_PTRCTL);
  wire logic dstIsPer = !dstSys && !dstIsPrefix;
  wire logic jumpOp = dstIsIp;
  // interrupt vectoring replaces the fetched word and pushes the return address
  wire logic takeIrq = irqReq && (prefix_ff == 5'h00); // prefix pair is never split
  wire logic stackPush = takeIrq || ((pushOp || callOp) && !takeIrq);
  wire logic stackPop = !takeIrq && (popOp || popiOp || retOp || retiOp);
  wire logic [15:0] pcPlus = pc_ff + 16'h0001;
  wire logic [15:0] pushValue = takeIrq ? pc_ff : (callOp ? pcPlus : srcValue);

  // ==========================================
  // next program counter: one instruction per cycle, no pipeline
  always_comb begin
    nxt_pc = pcPlus;
    if (takeIrq) begin
      nxt_pc = irqVector;
    end else if (retOp || retiOp) begin
      nxt_pc = stackTop;
    end else if (jumpOp || callOp) begin
      nxt_pc = srcValue;
    end
  end

  // accumulator load, the pairing partner for arithmetic units
  assign nxt_acc = (dstIsAcc && !takeIrq) ? srcValue : acc_ff;
  // prefix lives for exactly one following instruction
  assign nxt_prefix = (dstIsPrefix && !takeIrq) ? srcValue[4:0] : 5'h00;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pc_ff <= `UROM_BASE;
      acc_ff <= 16'h0000;
      prefix_ff <= 5'h00;
    end else begin
      pc_ff <= nxt_pc;
      acc_ff <= nxt_acc;
      prefix_ff <= nxt_prefix;
    end
  end

  // ==========================================
  // pointer step modes, written through the pointer control module
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      step_ff[0] <= STEP_NONE;
      step_ff[1] <= STEP_NONE;
      step_ff[2] <= STEP_NONE;
    end else if (dstIsPtrCtl && !takeIrq) begin
      step_ff[dstPtrSel] <= srcValue[1:0];
    end
  end

  // ==========================================
  // stack and three data pointers
  hw_stack #(.DEPTH(`STACK_DEPTH), .WIDTH(16)) u_stack (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pushReq(stackPush),
    .popReq(stackPop),
    .pushData(pushValue),
    .topData(stackTop),
    .stackPtr(stackPointer)
  );

  // the pointer that moves is the one used for this cycle's memory access
  wire logic [1:0] accPtr = dstIsPtrMem ? dstPtrSel : ptrSel;
  wire logic memAccess = (srcIsPtrMem || dstIsPtrMem) && !takeIrq;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ptr
      data_pointer #(.AW(16)) u_ptr (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .loadEn(dstIsPer && 1'b0),
        .loadVal(srcValue),
        .accessEn(memAccess && (accPtr == 2'(g))),
        .stepMode(step_ff[g]),
        .ptrVal(ptrVal[g])
      );
    end
  endgenerate

  // ==========================================
  // memory map decode
  wire map_mode_t mode = map_mode_t'(mapMode);
  wire logic inUrom = (pc_ff >= `UROM_BASE) && (pc_ff < `UROM_BASE + 16'(`UROM_WORDS));
  wire logic vnData = (mode == MAP_VON_NEUMANN) && (pc_ff >= `VN_DATA_BASE) &&
    (pc_ff < `VN_DATA_BASE + 16'(`DATA_WORDS));
  wire logic dicData = (mode == MAP_DATA_IN_CODE) && (pc_ff >= `DATA_IN_CODE_BASE) &&
    (pc_ff < `DATA_IN_CODE_BASE + 16'(`DATA_WORDS));
  wire logic [15:0] memAddr = ptrVal[accPtr];
  // constants read through data space above the data SRAM
  wire logic cidCode = ((mode == MAP_CODE_IN_DATA) || (mode == MAP_VON_NEUMANN)) &&
    (memAddr >= 16'(`DATA_WORDS));

  assign codeAddr = pc_ff;
  assign codeSelUrom = inUrom && !vnData && !dicData;
  assign codeSelData = vnData || dicData;
  assign dataAddr = cidCode ? memAddr : {8'h00, memAddr[DATA_AW-1:0]};
  assign dataSelCode = cidCode;
  assign dataRd = srcIsPtrMem && !takeIrq;
  assign dataWr = dstIsPtrMem && !takeIrq;
  assign dataWdata = srcValue;

  // peripheral module access, plus the register moves carrying side effects
  assign perMod = dstIsPer ? dstMod : srcMod;
  assign perSrcIdx = srcIdx;
  assign perDstIdx = dstIdx;
  assign perRd = !srcImm && !srcMod[3] && !takeIrq;
  assign perWr = dstIsPer && !takeIrq;
  assign perWdata = srcValue;
  assign accValue = acc_ff;
  assign progCounter = pc_ff;

  // ==========================================
  // code lock and key check for outside tool access
  // key words are compared one at a time to avoid a 256-bit comparator
  always_comb begin
    nxt_pw = pw_ff;
    case (pw_ff)
      PW_LOCKED: begin
        if (!lock_ff) begin
          nxt_pw = PW_OPEN;
        end else if (keyValid) begin
          nxt_pw = PW_CHECK;
        end
      end
      PW_CHECK: begin
        if (!lock_ff) begin
          nxt_pw = PW_OPEN;
        end else if (keyValid && (key_idx_ff == 4'hf)) begin
          nxt_pw = (key_bad_ff || (keyWord != codeRdata)) ? PW_LOCKED : PW_OPEN;
        end
      end
      PW_OPEN: begin
        nxt_pw = PW_OPEN;
      end
      default: begin
        nxt_pw = PW_LOCKED;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lock_ff <= 1'b1;
      pw_ff <= PW_LOCKED;
      key_idx_ff <= 4'h0;
      key_bad_ff <= 1'b0;
    end else begin
      if (lockClear) begin
        lock_ff <= 1'b0;
      end
      pw_ff <= nxt_pw;
      if (keyValid && (pw_ff != PW_OPEN)) begin
        key_idx_ff <= key_idx_ff + 4'h1;
        key_bad_ff <= (key_idx_ff != 4'hf) && (key_bad_ff || (keyWord != codeRdata));
      end
    end
  end

  assign keyReq = (pw_ff != PW_OPEN);
  assign keyIdx = key_idx_ff; // key word keyIdx is compared with the code word fetched at pc_ff
  assign codeLockBit = lock_ff;
  assign toolAccessOk = (pw_ff == PW_OPEN) || !lock_ff;
endmodule

/* hw/core_defines.svh */
// constants for the transport-triggered core decode block
`ifndef CORE_DEFINES_SVH
`define CORE_DEFINES_SVH
// ==========================================
// instruction word fields
`define FMT_BIT 15
`define SRC_LSB 0
`define SRC_MSB 7
`define SRC_MOD_W 4
`define DST_LSB 8
`define DST_MSB 14
`define DST_MOD_W 4
`define DST_SUB_W 3
// ==========================================
// system module specifiers and register indexes
`define MOD_ACC 4'h9
`define MOD_PREFIX 4'hb
`define MOD_IP 4'hc
`define MOD_STACK 4'hd
`define MOD_PTRCTL 4'he
`define MOD_PTR 4'hf
`define IDX_STACKPTR 4'h1
`define IDX_PUSH 4'h0
`define IDX_POP 4'h3
`define IDX_STACK_LOAD_INT_OP 4'h4
`define IDX_CALL 4'h5
`define IDX_RET 4'h6
`define IDX_INTERRUPT_EXIT 4'h7
`define IDX_PTR0 4'h3
`define IDX_PTR1 4'h7
`define IDX_PTR2 4'hb
`define IDX_PTRCTL 4'h4
`define IDX_JUMP 4'hc
// ==========================================
// stack, memory map and reset values
`define STACK_DEPTH 16
`define STACK_PTR_RST 4'hf
`define UROM_BASE 16'h8000
`define UROM_WORDS 4096
`define DATA_WORDS 256
`define CODE_WORDS 65536
`define DATA_IN_CODE_BASE 16'ha000
`define CODE_IN_DATA_BASE 16'h8000
`define VN_DATA_BASE 16'h9000
`define PWD_FIRST 16'h0010
`define PWD_LAST 16'h001f
`define PWD_WORDS 16
`define APP_START 16'h0000
`endif

/* hw/core_pkg.sv */
// types shared by the core decode files
package core_pkg;
  typedef enum logic [1:0] {
    MAP_HARVARD = 2'b00,
    MAP_DATA_IN_CODE = 2'b01,
    MAP_CODE_IN_DATA = 2'b10,
    MAP_VON_NEUMANN = 2'b11
  } map_mode_t;
  typedef enum logic [1:0] {
    STEP_NONE = 2'b00,
    STEP_INC = 2'b01,
    STEP_DEC = 2'b10
  } step_mode_t;
  typedef enum logic [1:0] {
    PW_LOCKED = 2'b00,
    PW_CHECK = 2'b01,
    PW_OPEN = 2'b10
  } pw_state_t;
endpackage

/* hw/hw_stack.sv */
// sixteen-entry hardware stack with pre-increment push and post-decrement pop
`timescale 1ns/1ps
`include "core_defines.svh"
module hw_stack #(
  parameter int DEPTH = `STACK_DEPTH,
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // stack operations
  input wire logic pushReq,
  input wire logic popReq,
  input wire logic [WIDTH-1:0] pushData,
  // state
  output logic [WIDTH-1:0] topData,
  output logic [$clog2(DEPTH)-1:0] stackPtr
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [$clog2(DEPTH)-1:0] stack_ptr_ff;
  logic [$clog2(DEPTH)-1:0] nxt_stack_ptr;
  wire logic [$clog2(DEPTH)-1:0] incPtr = stack_ptr_ff + 1'b1;

  // pop reads current entry then steps down; push steps up then writes
  assign nxt_stack_ptr = pushReq ? incPtr : (popReq ? stack_ptr_ff - 1'b1 : stack_ptr_ff);
  assign topData = mem[stack_ptr_ff];
  assign stackPtr = stack_ptr_ff;

  // pointer wraps silently; overflow is software's concern
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stack_ptr_ff <= `STACK_PTR_RST;
    end else begin
      stack_ptr_ff <= nxt_stack_ptr;
    end
  end

  // entries hold no reset so the array maps onto plain storage
  always_ff @(posedge ref_clk) begin
    if (pushReq) begin
      mem[incPtr] <= pushData;
    end
  end
endmodule

/* hw/data_pointer.sv */
// one auto-stepping data memory pointer
`timescale 1ns/1ps
module data_pointer #(
  parameter int AW = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // control
  input wire logic loadEn,
  input wire logic [AW-1:0] loadVal,
  input wire logic accessEn,
  input wire logic [1:0] stepMode,
  // state
  output logic [AW-1:0] ptrVal
);
  import core_pkg::*;
  logic [AW-1:0] ptr_ff;
  logic [AW-1:0] nxt_ptr;
  wire logic doInc = accessEn && (stepMode == STEP_INC);
  wire logic doDec = accessEn && (stepMode == STEP_DEC);

  // step happens after the access, with no software action
  assign nxt_ptr = loadEn ? loadVal : (doInc ? ptr_ff + 1'b1 : (doDec ? ptr_ff - 1'b1 : ptr_ff));
  assign ptrVal = ptr_ff;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ptr_ff <= '0;
    end else begin
      ptr_ff <= nxt_ptr;
    end
  end
endmodule

/* test/core_decode_monitor.sv */
// assertion checker watching the ports of the core decode block
`timescale 1ns/1ps
module core_decode_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // fetch and memory map
  input wire logic [15:0] codeAddr,
  input wire logic [15:0] codeRdata,
  input wire logic codeSelUrom,
  input wire logic codeSelData,
  input wire logic [15:0] dataAddr,
  input wire logic dataRd,
  input wire logic dataSelCode,
  input wire logic [1:0] mapMode,
  // peripheral side
  input wire logic [3:0] perMod,
  input wire logic [3:0] perSrcIdx,
  input wire logic [7:0] perDstIdx,
  input wire logic perRd,
  input wire logic perWr,
  // control and status
  input wire logic irqReq,
  input wire logic lockClear,
  input wire logic codeLockBit,
  input wire logic toolAccessOk,
  input wire logic [3:0] stackPointer,
  input wire logic [15:0] progCounter
);
  // ======================================
  // helper decode of the fetched word
  logic pfxPend_ff;
  wire nxt_pfxPend = (irqReq && !pfxPend_ff) ? 1'b0 : (codeRdata[11:8] == 4'hb);
  wire isPop = codeRdata[15] && (codeRdata[7:0] == 8'h3d) && (codeRdata[14:8] != 7'h0d);
  wire isPush = (codeRdata[14:8] == 7'h0d) && !isPop;
  // pending prefix blocks the stack checks: the destination then is not the plain one
  wire run = !irqReq && !pfxPend_ff;
  // prefix tracker, dropped when an interrupt swallows the word
  always_ff @(posedge ref_clk) begin
    if (sys_rst) pfxPend_ff <= 1'b0;
    else pfxPend_ff <= nxt_pfxPend;
  end
  // ======================================
  // properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  chk_reset_state: assert property (disable iff (1'b0) $fell(sys_rst) |->
    stackPointer == 4'hf && progCounter == 16'h8000 && codeLockBit) else $error("bad state after reset");
  chk_urom_place: assert property (mapMode != 2'b11 |->
    codeSelUrom == (codeAddr[15:12] == 4'h8)) else $error("utility rom select wrong");
  chk_harvard_split: assert property (mapMode == 2'b00 |-> !codeSelData && !dataSelCode)
    else $error("spaces not separate");
  chk_code_const: assert property (mapMode == 2'b10 && dataRd && dataAddr[15:8] != 8'h00 |-> dataSelCode)
    else $error("code not seen in data space");
  chk_push_order: assert property (run && isPush |=> stackPointer == $past(stackPointer) + 4'h1)
    else $error("push did not step pointer up");
  chk_pop_order: assert property (run && isPop |=> stackPointer == $past(stackPointer) - 4'h1)
    else $error("pop did not step pointer down");
  chk_irq_stack: assert property (irqReq && !pfxPend_ff |-> !perWr ##1
    stackPointer == $past(stackPointer) + 4'h1) else $error("interrupt stack push wrong");
  chk_prefix_use: assert property (pfxPend_ff && perWr && !$past(codeRdata[15]) |->
    perDstIdx[7:3] == $past(codeRdata[4:0])) else $error("prefix bits not applied");
  chk_prefix_clear: assert property (!pfxPend_ff && perWr |-> perDstIdx[7:3] == 5'h00)
    else $error("prefix bits leaked");
  chk_dst_fields: assert property (perWr && !perRd |->
    perMod == codeRdata[11:8] && perDstIdx[2:0] == codeRdata[14:12]) else $error("destination fields wrong");
  chk_src_fields: assert property (perRd && !perWr |-> codeRdata[15] &&
    perMod == codeRdata[3:0] && perSrcIdx == codeRdata[7:4]) else $error("source fields wrong");
  chk_lock_clear: assert property (lockClear |=> !codeLockBit && toolAccessOk)
    else $error("lock bit not cleared");
  // main scenarios
  cov_push: cover property (run && isPush);
  cov_pop: cover property (run && isPop);
  cov_prefix: cover property (pfxPend_ff && perWr);
endmodule
bind core_decode core_decode_monitor mon (.ref_clk(ref_clk), .sys_rst(sys_rst), .codeAddr(codeAddr),
  .codeRdata(codeRdata), .codeSelUrom(codeSelUrom), .codeSelData(codeSelData), .dataAddr(dataAddr),
  .dataRd(dataRd), .dataSelCode(dataSelCode), .mapMode(mapMode), .perMod(perMod), .perSrcIdx(perSrcIdx),
  .perDstIdx(perDstIdx), .perRd(perRd), .perWr(perWr), .irqReq(irqReq), .lockClear(lockClear),
  .codeLockBit(codeLockBit), .toolAccessOk(toolAccessOk), .stackPointer(stackPointer), .progCounter(progCounter));

/* test/mem_partner.sv */
// program, data and peripheral memory model facing the core decode block
`timescale 1ns/1ps
module mem_partner (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // program side
  input wire logic [15:0] codeAddr,
  input wire logic codeSelData,
  output logic [15:0] codeRdata,
  // data side
  input wire logic [15:0] dataAddr,
  input wire logic dataRd,
  input wire logic dataWr,
  input wire logic [15:0] dataWdata,
  input wire logic dataSelCode,
  output logic [15:0] dataRdata,
  // peripheral side
  input wire logic [3:0] perMod,
  input wire logic [3:0] perSrcIdx,
  input wire logic [7:0] perDstIdx,
  input wire logic perRd,
  input wire logic perWr,
  input wire logic [15:0] perWdata,
  output logic [15:0] perRdata
);
  // ======================================
  // storage: 64K code words, 256 data words
  logic [15:0] code [0:65535];
  logic [15:0] data [0:255];
  logic [23:0] wrLog [$];
  logic flip = 1'b0;
  initial begin
    foreach (data[i]) data[i] = 16'h0000;
  end
  // writes land at the edge; peripheral writes are logged for the bench
  always @(posedge ref_clk) begin
    flip <= ~flip;
    if (dataWr && !sys_rst && dataSelCode) code[dataAddr] <= dataWdata;
    if (dataWr && !sys_rst && !dataSelCode) data[dataAddr[7:0]] <= dataWdata;
    if (perWr && !sys_rst) wrLog.push_back({perDstIdx, perWdata});
  end
  // reads are combinational; idle read lines toggle so stale data never looks valid
  assign codeRdata = codeSelData ? data[codeAddr[7:0]] : code[codeAddr];
  assign dataRdata = !dataRd ? ({16{flip}} ^ 16'h5a5a) : dataSelCode ? code[dataAddr] : data[dataAddr[7:0]];
  assign perRdata = perRd ? {8'hc3, perSrcIdx, perMod} : ({16{flip}} ^ 16'ha5a5);
endmodule

/* test/core_decode_tb.sv */
// self-checking bench for the core decode block
`timescale 1ns/1ps
module core_decode_tb;
  // ======================================
  // signals
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] codeAddr, codeRdata, dataAddr, dataWdata, dataRdata, perWdata, perRdata;
  logic [15:0] irqVector, keyWord, accValue, progCounter;
  logic codeSelUrom, codeSelData, dataRd, dataWr, dataSelCode, perRd, perWr, irqReq, lockClear;
  logic keyValid, keyReq, codeLockBit, toolAccessOk;
  logic [3:0] perMod, perSrcIdx, keyIdx, stackPointer;
  logic [7:0] perDstIdx;
  logic [1:0] mapMode;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [15:0] prog [$];
  int expSp [$];
  int expAcc [$];
  int stk [16];
  int dmem [3];
  int sp, acc, v;
  always #50 ref_clk = ~ref_clk;
  core_decode DUT (.*);
  mem_partner mem (.*);
  // ======================================
  // shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic results();
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // records a word and the model state expected once it has run
  task automatic put(input logic [15:0] instr);
    prog.push_back(instr);
    expSp.push_back(sp);
    expAcc.push_back(acc);
  endtask
  // hang guard, far above the 70 cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 1000) begin
      n_errors++;
      results();
    end
  end
  // ======================================
  // main sequence
  initial begin
    irqReq = 1'b0;
    irqVector = 16'h0000;
    mapMode = 2'b00;
    lockClear = 1'b0;
    keyValid = 1'b0;
    keyWord = 16'h0000;
    void'($urandom(32'h3e96c1f2));
    sp = 15;
    acc = 0;
    // fill all sixteen entries, then drain them into the accumulator
    for (int i = 0; i < 16; i++) begin
      v = $urandom % 256;
      sp = (sp + 1) % 16;
      stk[sp] = v;
      put(16'h0d00 | 16'(v));
    end
    for (int i = 0; i < 16; i++) begin
      acc = stk[sp];
      sp = (sp + 15) % 16;
      put(16'h893d);
    end
    // pointer 0 steps up over two stores, then down over three loads
    put(16'h0e01);
    for (int i = 0; i < 2; i++) begin
      dmem[i] = $urandom % 256;
      put(16'h0f00 | 16'(dmem[i]));
    end
    put(16'h0e02);
    for (int i = 2; i >= 0; i--) begin
      acc = dmem[i];
      put(16'h893f);
    end
    // prefix then two peripheral writes, a peripheral read, an immediate load
    put(16'h0b03);
    put(16'h1255);
    put(16'h1255);
    acc = 'hc342;
    put(16'h8942);
    acc = 'h77;
    put(16'h0977);
    for (int i = 0; i < 65536; i++) mem.code[i] = 16'h8909;
    foreach (prog[i]) mem.code[16'h8000 + i] = prog[i];
    repeat (20) @(negedge ref_clk);
    check(16'(stackPointer), 16'h000f, "reset pointer");
    check(progCounter, 16'h8000, "reset start");
    check(16'(codeLockBit), 16'h0001, "reset lock");
    check(16'(keyReq), 16'h0001, "key asked");
    check(16'(keyIdx), 16'h0000, "key index");
    sys_rst = 1'b0;
    // one word per cycle, map mode shuffled among the modes that keep the rom in place
    foreach (prog[i]) begin
      mapMode = 2'($urandom % 3);
      @(negedge ref_clk);
      check(16'(stackPointer), 16'(expSp[i]), "stack pointer");
      check(accValue, 16'(expAcc[i]), "accumulator");
      check(progCounter, 16'h8001 + 16'(i), "program counter");
      check(16'(codeSelUrom), 16'h0001, "rom select");
    end
    check(16'(mem.wrLog.size()), 16'h0002, "write count");
    check({8'h00, mem.wrLog[0][23:16]}, 16'h0019, "prefixed index");
    check({8'h00, mem.wrLog[1][23:16]}, 16'h0001, "plain index");
    check(mem.wrLog[1][15:0], 16'h0055, "write data");
    // interrupt: word dropped, return address stacked, vector taken
    v = $urandom;
    irqVector = {4'h4, 12'(v)};
    irqReq = 1'b1;
    @(negedge ref_clk);
    irqReq = 1'b0;
    check(16'(stackPointer), 16'(sp + 1) & 16'h000f, "irq pointer");
    check(progCounter, irqVector, "irq vector");
    lockClear = 1'b1;
    @(negedge ref_clk);
    lockClear = 1'b0;
    check(16'(codeLockBit), 16'h0000, "lock cleared");
    check(16'(toolAccessOk), 16'h0001, "tool access");
    mapMode = 2'b11;
    repeat (4) @(negedge ref_clk);
    check(16'(keyReq), 16'h0000, "key no longer asked");
    results();
  end
endmodule
